/* File: dv/alert_status_and_pin_routing_bench.sv */
/*
  Self-checking bench of the alert status and pin routing block.
  Assumes asapr_pkg, the design, the host model and checker are compiled.
*/
module alert_status_and_pin_routing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import asapr_pkg::*;
  localparam logic [11:0] A_ST = {ASAPR_IDX_STATUS, 2'h0};
  localparam logic [11:0] A_RT = {ASAPR_IDX_ROUTE, 2'h0};
  localparam logic [11:0] A_EN = {ASAPR_IDX_ENABLE, 2'h0};
  localparam logic [11:0] A_FN = {ASAPR_IDX_PINFN, 2'h0};
  localparam logic [11:0] A_IS = {ASAPR_IDX_IRQ_STS, 2'h0};
  localparam logic [11:0] A_IM = {ASAPR_IDX_IRQ_MASK, 2'h0};
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  asapr_apb_req_s apb_req = '0;
  asapr_apb_rsp_s apb_rsp;
  logic conv_done = 1'b0;
  asapr_trip_s trip = '0;
  logic extra_alert_src = 1'b0;
  logic host_lvl = 1'b0;
  logic pin_in, pin_out, pin_oe, slow_request, irq;
  logic [31:0] rd_data;
  logic rd_err;
  int err_count = 0;
  int samples_checked = 0;
  logic [11:0] regs [6] = '{A_ST, A_RT, A_EN, A_FN, A_IS, A_IM};
  logic [24:0] rtrip [7] = '{25'h1000000, 25'h0020000, 25'h0008000,
    25'h0000400, 25'h0000100, 25'h0000002, 25'h0000001};
  logic [23:0] rexp [7] = '{24'h800000, 24'h010000, 24'h004000,
    24'h000200, 24'h000080, 24'h000008, 24'h000004};

  always #25 clk_sys = ~clk_sys;

  asapr_top u_asapr_top
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .conv_done(conv_done),
    .trip(trip),
    .extra_alert_src(extra_alert_src),
    .shared_slow_alert_pin_in(pin_in),
    .shared_slow_alert_pin_out(pin_out),
    .shared_slow_alert_pin_oe(pin_oe),
    .slow_request(slow_request),
    .irq(irq)
  );

  asapr_host_model u_asapr_host_model
  (
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .host_lvl(host_lvl),
    .pin_level(pin_in)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
    rd_data = apb_rsp.prdata;
    rd_err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd_data, exp);
  endtask

  task automatic conv();
    @(posedge clk_sys);
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
  endtask

  task automatic results();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (regs[i])
      rchk(regs[i], 32'h0);
    trip <= '1;
    conv();
    trip <= '0;
    rchk(A_ST, 32'h0000000C);
    conv();
    apb(1'b1, A_EN, 32'h00FFFFFF);
    foreach (rtrip[i])
    begin
      trip <= rtrip[i];
      conv();
      trip <= '0;
      rchk(A_ST, {8'h00, rexp[i]});
      conv();
      rchk(A_ST, 32'h0);
    end
    trip <= 25'h0800000;
    conv();
    rchk(A_ST, 32'h00400000);
    conv();
    rchk(A_ST, 32'h00400000);
    trip <= '0;
    conv();
    rchk(A_ST, 32'h0);
    apb(1'b1, A_IM, 32'h3);
    apb(1'b1, A_RT, 32'h00FFFFFF);
    rchk(A_RT, 32'h00FFFFFE);
    apb(1'b1, A_FN, 32'h1);
    trip <= 25'h0010000;
    conv();
    trip <= '0;
    repeat (2) @(posedge clk_sys);
    check(pin_out, 1'b1);
    check(irq, 1'b1);
    apb(1'b1, A_IS, 32'h3);
    @(posedge clk_sys);
    check(irq, 1'b0);
    apb(1'b1, A_ST, 32'hFFFFFFFF);
    rchk(A_ST, 32'h00008000);
    apb(1'b1, A_RT, 32'h0);
    repeat (2) @(posedge clk_sys);
    check(pin_out, 1'b0);
    apb(1'b1, A_RT, 32'h2);
    extra_alert_src <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(pin_out, 1'b1);
    extra_alert_src <= 1'b0;
    apb(1'b1, A_FN, 32'h0);
    repeat (2) @(posedge clk_sys);
    check(pin_oe, 1'b0);
    check(pin_out, 1'b0);
    host_lvl <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check(slow_request, 1'b1);
    apb(1'b1, A_EN, 32'h0);
    rchk(A_EN, 32'h0);
    apb(1'b0, 12'h0B0, 32'h0);
    check(rd_err, 1'b1);
    check(rd_data, 32'h0);
    results();
  end
endmodule

/* File: dv/asapr_host_model.sv */
/*
  Host side of the shared slow/alert wire.
  Assumes the device drives the wire only while its enable is high.
*/
module asapr_host_model
(
  // Device side.
  input logic pin_out,
  input logic pin_oe,
  // Host side.
  input logic host_lvl,
  // Resolved wire level.
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_level = pin_oe ? pin_out : host_lvl;
endmodule

/* File: dv/asapr_top_chk.sv */
/*
  Port checker for the alert status block, bound to asapr_top.
  Assumes asapr_pkg is compiled before this file.
*/
module asapr_top_chk
(
  // Clock and reset.
  input logic clk_sys,
  input logic resetn,
  // Bus.
  input asapr_pkg::asapr_apb_req_s apb_req,
  input asapr_pkg::asapr_apb_rsp_s apb_rsp,
  // Pin and interrupt.
  input logic shared_slow_alert_pin_in,
  input logic shared_slow_alert_pin_out,
  input logic shared_slow_alert_pin_oe,
  input logic slow_request,
  input logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import asapr_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  logic acc;
  logic rd;
  logic mapped;
  logic [9:0] ix;
  assign acc = apb_req.psel && apb_req.penable;
  assign rd = acc && !apb_req.pwrite;
  assign ix = apb_req.paddr[11:2];
  assign mapped = ix inside {ASAPR_IDX_STATUS, ASAPR_IDX_ROUTE,
    ASAPR_IDX_ENABLE, ASAPR_IDX_PINFN, ASAPR_IDX_IRQ_STS, ASAPR_IDX_IRQ_MASK};
  chk_ready_high: assert property (apb_rsp.pready)
    else $error("pready low");
  chk_unmapped_err: assert property (acc && !mapped |-> apb_rsp.pslverr)
    else $error("no error on unmapped address");
  chk_mapped_ok: assert property (acc && mapped |-> !apb_rsp.pslverr)
    else $error("error on mapped address");
  chk_rd_upper: assert property (rd |-> apb_rsp.prdata[31:24] == 8'h00)
    else $error("upper read bits set");
  chk_status_low: assert property (rd && ix == ASAPR_IDX_STATUS |->
    apb_rsp.prdata[1:0] == 2'h0)
    else $error("status bits 1 to 0 set");
  chk_route_bit0: assert property (rd && ix == ASAPR_IDX_ROUTE |->
    apb_rsp.prdata[0] == 1'h0)
    else $error("routing bit 0 set");
  chk_oe_mode: assert property (acc && apb_req.pwrite &&
    ix == ASAPR_IDX_PINFN |=>
    shared_slow_alert_pin_oe == $past(apb_req.pwdata[0]))
    else $error("pin enable does not follow function");
  chk_out_needs_oe: assert property (!shared_slow_alert_pin_oe[*2] |->
    !shared_slow_alert_pin_out)
    else $error("alert driven in slow mode");
  chk_slow_tracks: assert property ((!shared_slow_alert_pin_oe &&
    $stable(shared_slow_alert_pin_in))[*6] |->
    slow_request == shared_slow_alert_pin_in)
    else $error("slow request does not follow pin");
  cover property (acc && !mapped);
  cover property ($rose(shared_slow_alert_pin_out));
  cover property ($rose(irq));
endmodule
bind asapr_top asapr_top_chk u_asapr_top_chk
(
  .clk_sys(clk_sys),
  .resetn(resetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .shared_slow_alert_pin_in(shared_slow_alert_pin_in),
  .shared_slow_alert_pin_out(shared_slow_alert_pin_out),
  .shared_slow_alert_pin_oe(shared_slow_alert_pin_oe),
  .slow_request(slow_request),
  .irq(irq)
);

/* File: include/asapr_pkg.sv */
/*
  Shared constants and carrier types of the alert status and pin routing
  block: register indices, reset values, field positions and the structs
  that carry bus, trip and state signals.
  Assumes the design files import this package whole.
*/
package asapr_pkg;

  // Word indices; the byte address is four times the index.
  localparam logic [9:0] ASAPR_IDX_STATUS = 10'h026;
  localparam logic [9:0] ASAPR_IDX_ROUTE = 10'h027;
  localparam logic [9:0] ASAPR_IDX_ENABLE = 10'h028;
  localparam logic [9:0] ASAPR_IDX_PINFN = 10'h029;
  localparam logic [9:0] ASAPR_IDX_IRQ_STS = 10'h02A;
  localparam logic [9:0] ASAPR_IDX_IRQ_MASK = 10'h02B;

  // Values after reset.
  localparam logic [23:0] ASAPR_ROUTE_RST = 24'h000000;
  localparam logic [23:0] ASAPR_ENABLE_RST = 24'h000000;
  localparam logic ASAPR_PINFN_RST = 1'h0;
  localparam logic [1:0] ASAPR_IRQ_RST = 2'h0;
  localparam logic [2:0] ASAPR_SYNC_RST = 3'h0;
  localparam logic [31:0] ASAPR_RDATA_RST = 32'h00000000;

  // Field positions and masks.
  localparam int unsigned ASAPR_NFLAG = 22;
  localparam int unsigned ASAPR_FLAG_LSB = 2;
  localparam int unsigned ASAPR_EXTRA_BIT = 1;
  localparam logic [23:0] ASAPR_ROUTE_WMASK = 24'hFFFFFE;
  localparam logic [23:0] ASAPR_ENABLE_WMASK = 24'hFFFFF0;
  localparam logic [21:0] ASAPR_ALWAYS_EN = 22'h000003;
  localparam int unsigned ASAPR_IRQ_NEWFLAG = 0;
  localparam int unsigned ASAPR_IRQ_PINRISE = 1;

  // Flag layout, bits 23 to 2; index 3 of each nibble is channel one.
  typedef struct packed {
    logic [3:0] oc;
    logic [3:0] uc;
    logic [3:0] ov;
    logic [3:0] uv;
    logic [3:0] op;
    logic acc_full;
    logic cnt_full;
  } asapr_flags_s;

  // Raw trip conditions from the measurement logic.
  typedef struct packed {
    logic [3:0] oc;
    logic [3:0] uc;
    logic [3:0] ov;
    logic [3:0] uv;
    logic [3:0] op;
    logic [3:0] acc_chan_full;
    logic cnt_full;
  } asapr_trip_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } asapr_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } asapr_apb_rsp_s;

  typedef struct packed {
    logic flag;
    logic pending;
  } asapr_cell_s;

  typedef struct packed {
    logic [23:0] route;
    logic [23:0] enable;
    logic alert_mode;
    logic [1:0] irq_sts;
    logic [1:0] irq_mask;
    logic [2:0] sync;
    logic slow_lvl;
    logic pin_alert;
    logic [31:0] prdata;
    logic pslverr;
  } asapr_top_s;

endpackage

/* File: src/asapr_flag_cell.sv */
/*
  One read-clear alert flag with its clear-pending mark.
  Assumes conv_done and rd_clear are one-cycle pulses on clk_sys.
*/
module asapr_flag_cell
(
  // Clock and reset.
  input logic clk_sys,
  input logic resetn,
  // Events.
  input logic conv_done,
  input logic cond,
  input logic rd_clear,
  // Flag.
  output logic flag
);
  import asapr_pkg::*;

  asapr_cell_s st_ff;
  asapr_cell_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (conv_done)
    begin
      if (st_ff.pending)
      begin
        nxt_st.flag = cond;
        nxt_st.pending = 1'b0;
      end
      else if (cond)
      begin
        nxt_st.flag = 1'b1;
      end
    end
    if (rd_clear)
    begin
      nxt_st.pending = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '{flag: 1'b0, pending: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign flag = st_ff.flag;

endmodule

/* File: src/asapr_top.sv */
/*
  Alert status and shared pin routing of a four-channel power monitor,
  with an APB register slave and one level interrupt.
  Assumes conv_done is a one-cycle pulse and the trip conditions are
  levels, both from logic on clk_sys; the shared pin arrives unsynced.
*/
// Local design decision: register access over APB.
// Function
// - Status register shows each alert source's flag.
// - Flag clears after read plus next conversion.
// - Still-present condition keeps flag set after read.
// - Flags visible without any snapshot refresh.
// - Alert types disabled after reset, enable bits; bits 3..2 always enabled.
// - Bits 23..20 overcurrent, channels one to four.
// - Bits 19..16 undercurrent, channels one to four.
// - Bits 15..12 overvoltage, channels one to four.
// - Bits 11..8 undervoltage, channels one to four.
// - Bits 7..4 overpower; bits 1..0 zero.
// - Bit 3 any accumulator full or overflow.
// - Bit 2 sample counter full or overflow.
// - Writable routing register selects pin sources.
// - Routing drives pin only in alert mode.
// - Routing bits mirror status; bit 1 extra.
module asapr_top
(
  // Clock and reset.
  input logic clk_sys,
  input logic resetn,
  // APB slave.
  input asapr_pkg::asapr_apb_req_s apb_req,
  output asapr_pkg::asapr_apb_rsp_s apb_rsp,
  // Measurement side.
  input logic conv_done,
  input asapr_pkg::asapr_trip_s trip,
  input logic extra_alert_src,
  // Shared slow/alert pin.
  input logic shared_slow_alert_pin_in,
  output logic shared_slow_alert_pin_out,
  output logic shared_slow_alert_pin_oe,
  output logic slow_request,
  // Interrupt.
  output logic irq
);
  import asapr_pkg::*;

  asapr_top_s st_ff;
  asapr_top_s nxt_st;
  asapr_flags_s cond_vec;
  asapr_flags_s flags;
  logic [21:0] cond_bits;
  logic [21:0] flag_bits;
  logic [21:0] en_eff;
  logic [21:0] rd_clear;
  logic [23:0] status_word;
  logic [9:0] widx;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic rd_acc;
  logic hit_status;
  logic hit_route;
  logic hit_enable;
  logic hit_pinfn;
  logic hit_irq_sts;
  logic hit_irq_mask;
  logic hit_any;
  logic evt_newflag;
  logic evt_pinrise;
  logic routed_alert;

  // Bus phase decode and word address.
  assign widx = apb_req.paddr[11:2];
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign wr_acc = access_ph && apb_req.pwrite;
  assign rd_acc = access_ph && !apb_req.pwrite;

  assign hit_status = (widx == ASAPR_IDX_STATUS);
  assign hit_route = (widx == ASAPR_IDX_ROUTE);
  assign hit_enable = (widx == ASAPR_IDX_ENABLE);
  assign hit_pinfn = (widx == ASAPR_IDX_PINFN);
  assign hit_irq_sts = (widx == ASAPR_IDX_IRQ_STS);
  assign hit_irq_mask = (widx == ASAPR_IDX_IRQ_MASK);
  assign hit_any = hit_status || hit_route || hit_enable ||
                   hit_pinfn || hit_irq_sts || hit_irq_mask;

  // Accumulator and sample counter flags have no enable bit and are always armed.
  assign en_eff = st_ff.enable[23:2] | ASAPR_ALWAYS_EN;

  // Trip conditions mapped onto the status layout, gated by enables.
  always_comb
  begin
    cond_vec.oc = trip.oc;
    cond_vec.uc = trip.uc;
    cond_vec.ov = trip.ov;
    cond_vec.uv = trip.uv;
    cond_vec.op = trip.op;
    cond_vec.acc_full = |trip.acc_chan_full;
    cond_vec.cnt_full = trip.cnt_full;
  end

  assign cond_bits = cond_vec & en_eff;

  // Read-clear arms only the flags that were captured for the reader.
  assign rd_clear = (rd_acc && hit_status) ? st_ff.prdata[23:2] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < ASAPR_NFLAG; gi = gi + 1)
    begin : g_flag
      asapr_flag_cell u_cell
      (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .conv_done(conv_done),
        .cond(cond_bits[gi]),
        .rd_clear(rd_clear[gi]),
        .flag(flag_bits[gi])
      );
    end
  endgenerate

  assign flags = flag_bits;

  // Flags read straight from the live cells.
  assign status_word = {flag_bits, 2'h0};

  // Pin alert level from routed and enabled flags.
  assign routed_alert = |(flag_bits & en_eff & st_ff.route[23:2]) ||
                        (st_ff.route[ASAPR_EXTRA_BIT] &&
                         extra_alert_src);

  assign evt_newflag = conv_done && |(cond_bits & ~flag_bits);
  assign evt_pinrise = nxt_st.pin_alert && !st_ff.pin_alert;

  always_comb
  begin
    nxt_st = st_ff;

    // Setup phase captures read data and the error answer.
    if (setup_ph)
    begin
      nxt_st.pslverr = !hit_any;
      nxt_st.prdata = ASAPR_RDATA_RST;
      if (hit_status)
      begin
        nxt_st.prdata = {8'h00, status_word};
      end
      if (hit_route)
      begin
        nxt_st.prdata = {8'h00, st_ff.route};
      end
      if (hit_enable)
      begin
        nxt_st.prdata = {8'h00, st_ff.enable};
      end
      if (hit_pinfn)
      begin
        nxt_st.prdata = {31'h00000000, st_ff.alert_mode};
      end
      if (hit_irq_sts)
      begin
        nxt_st.prdata = {30'h00000000, st_ff.irq_sts};
      end
      if (hit_irq_mask)
      begin
        nxt_st.prdata = {30'h00000000, st_ff.irq_mask};
      end
    end

    // Access phase writes; the status register ignores writes.
    if (wr_acc && hit_route)
    begin
      nxt_st.route = apb_req.pwdata[23:0] & ASAPR_ROUTE_WMASK;
    end
    if (wr_acc && hit_enable)
    begin
      nxt_st.enable = apb_req.pwdata[23:0] & ASAPR_ENABLE_WMASK;
    end
    if (wr_acc && hit_pinfn)
    begin
      nxt_st.alert_mode = apb_req.pwdata[0];
    end
    if (wr_acc && hit_irq_mask)
    begin
      nxt_st.irq_mask = apb_req.pwdata[1:0];
    end

    // Pin drive follows routing only in alert mode.
    nxt_st.pin_alert = st_ff.alert_mode && routed_alert;

    // Sticky interrupt status: write one clears, a new event wins.
    nxt_st.irq_sts = st_ff.irq_sts;
    if (wr_acc && hit_irq_sts)
    begin
      nxt_st.irq_sts = st_ff.irq_sts & ~apb_req.pwdata[1:0];
    end
    if (evt_newflag)
    begin
      nxt_st.irq_sts[ASAPR_IRQ_NEWFLAG] = 1'b1;
    end
    if (evt_pinrise)
    begin
      nxt_st.irq_sts[ASAPR_IRQ_PINRISE] = 1'b1;
    end

    // Slow input: three stages, a change counts when two agree.
    nxt_st.sync = {st_ff.sync[1:0], shared_slow_alert_pin_in};
    if (st_ff.sync[1] == st_ff.sync[2])
    begin
      nxt_st.slow_lvl = st_ff.sync[2];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= '{
        route: ASAPR_ROUTE_RST,
        enable: ASAPR_ENABLE_RST,
        alert_mode: ASAPR_PINFN_RST,
        irq_sts: ASAPR_IRQ_RST,
        irq_mask: ASAPR_IRQ_RST,
        sync: ASAPR_SYNC_RST,
        slow_lvl: 1'b0,
        pin_alert: 1'b0,
        prdata: ASAPR_RDATA_RST,
        pslverr: 1'b0
      };
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Bus answer: zero wait states, data and error from flops.
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = st_ff.prdata;
  assign apb_rsp.pslverr = st_ff.pslverr && access_ph;

  // Pin drive, active high while in alert mode.
  assign shared_slow_alert_pin_out = st_ff.pin_alert;
  assign shared_slow_alert_pin_oe = st_ff.alert_mode;
  assign slow_request = st_ff.slow_lvl && !st_ff.alert_mode;

  assign irq = |(st_ff.irq_sts & st_ff.irq_mask);

endmodule

/* File: src/asapr_unused_placeholder_none.sv */
/*
  Intentionally empty compilation unit.
  Assumes nothing.
*/
